/* rtl/tws_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tws_bus_if;
   logic scl_host_oe;
   logic sda_host_oe;
   logic sda_dev_oe;
   logic scl;
   logic sda;

   // Open-drain wired AND with pull-ups: any enabled driver pulls low.
   assign scl = ~scl_host_oe;
   assign sda = ~(sda_host_oe | sda_dev_oe);

   modport host (output scl_host_oe, output sda_host_oe, input scl, input sda);
   modport device (output sda_dev_oe, input scl, input sda);
endinterface
`default_nettype wire

/* rtl/tws_device.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - SDA falling while SCL high is start.
// - SDA rising while SCL high is stop.
// - SDA changes only while SCL low.
// - Master starts only on an idle bus; the host starts on command without checking that the bus is idle.
// - Eight data bits plus acknowledge per byte.
// - Acknowledger holds SDA low through the pulse.
// - Master makes all clocks, starts, stops.
// - After master nack, slave releases SDA.
// - Device acknowledges address and each written byte.
// - Master acks read bytes, nacks the last.
// - Unlimited byte count between start and stop.
// - Repeated start ends and begins transfers.
// - Hardware recognises address and direction.
// - Read direction makes device shift out data.
// - Device only pulls SDA low, never high.
// - Works at standard, fast and high speed.
// - Master code at low speed precedes high speed.
// - Master code is never acknowledged.
// - High speed lasts until a stop.
// - Address is fixed part plus strapped pins.
// - Address bit zero set means master read.
module tws_device (
   // User clock and reset
   input  wire logic  clock,
   input  wire logic  rstn,
   // Link clock that oversamples the bus lines
   input  wire logic  link_clock,
   // Bus lines
   tws_bus_if.device  bus,
   // Address straps
   input  wire logic  addr_select_hi_pin,
   input  wire logic  addr_select_lo_pin,
   // Received bytes
   output logic       rx_valid,
   output logic [7:0] rx_data,
   // Bytes to send
   input  wire logic  tx_write,
   input  wire logic [7:0] tx_data,
   output logic       tx_req,
   // Status
   output logic       hs_active
);

   tws_pkg::tws_link_s q;
   tws_pkg::tws_link_s next_q;
   tws_pkg::tws_user_s u;
   tws_pkg::tws_user_s next_u;
   logic [1:0]         link_rst_sync;
   logic               rise;
   logic               fall;
   logic               start;
   logic               stop;
   logic               byte_done;

   // Reset reaches the link domain through its own two-stage synchroniser.
   always_ff @(posedge link_clock) begin
      link_rst_sync <= {link_rst_sync[0], rstn};
   end

   always_comb begin
      next_q        = q;
      next_q.scl_s1 = bus.scl;
      next_q.scl_s2 = q.scl_s1;
      next_q.scl_d  = q.scl_s2;
      next_q.sda_s1 = bus.sda;
      next_q.sda_s2 = q.sda_s1;
      next_q.sda_d  = q.sda_s2;
      next_q.pin_s1 = {addr_select_hi_pin, addr_select_lo_pin};
      next_q.pin_s2 = q.pin_s1;
      rise          = q.scl_s2 & ~q.scl_d;
      fall          = ~q.scl_s2 & q.scl_d;
      // Any SDA edge with SCL high is a control condition, never data.
      start         = q.scl_s2 & q.scl_d & q.sda_d & ~q.sda_s2;
      stop          = q.scl_s2 & q.scl_d & ~q.sda_d & q.sda_s2;
      byte_done     = fall && (q.bitcnt == tws_pkg::BITS_PER_BYTE);
      // Straps are taken once, after the synchroniser has filled following reset.
      if (q.settle != 2'h3) begin
         next_q.settle = q.settle + 2'h1;
         if (q.settle == tws_pkg::ADDR_SETTLE) begin
            next_q.addr_lo = q.pin_s2;
         end
      end
      if (start) begin
         // A repeated start lands here too and opens a fresh transfer.
         next_q.state  = tws_pkg::TWS_ADDR;
         next_q.bitcnt = 4'h0;
         next_q.sda_oe = 1'b0;
      end else if (stop) begin
         next_q.state  = tws_pkg::TWS_IDLE;
         next_q.bitcnt = 4'h0;
         next_q.sda_oe = 1'b0;
         next_q.hs     = 1'b0;
      end else begin
         unique case (q.state)
            tws_pkg::TWS_IDLE, tws_pkg::TWS_IGNR: begin
               next_q.sda_oe = 1'b0;
            end
            tws_pkg::TWS_ADDR, tws_pkg::TWS_RX: begin
               if (rise && q.bitcnt != tws_pkg::BITS_PER_BYTE) begin
                  next_q.shreg  = {q.shreg[6:0], q.sda_s2};
                  next_q.bitcnt = q.bitcnt + 4'h1;
               end else if (byte_done) begin
                  next_q.bitcnt = 4'h0;
                  if (q.state == tws_pkg::TWS_ADDR) begin
                     if (q.shreg[7:1] == {tws_pkg::ADDR_FIXED, q.addr_lo}) begin
                        next_q.sda_oe   = 1'b1;
                        next_q.dir_read = q.shreg[0];
                        next_q.state    = tws_pkg::TWS_ACK;
                     end else begin
                        // Master codes stay unanswered but arm high speed.
                        if (q.shreg[7:3] == tws_pkg::MCODE_TOP) begin
                           next_q.hs = 1'b1;
                        end
                        next_q.state = tws_pkg::TWS_IGNR;
                     end
                  end else begin
                     next_q.rx_byte = q.shreg;
                     next_q.rx_tgl  = ~q.rx_tgl;
                     next_q.sda_oe  = 1'b1;
                     next_q.state   = tws_pkg::TWS_ACK;
                  end
               end
            end
            tws_pkg::TWS_ACK: begin
               if (fall) begin
                  next_q.bitcnt = 4'h0;
                  if (q.dir_read) begin
                     next_q.shreg  = u.tx_data;
                     next_q.sda_oe = ~u.tx_data[7];
                     next_q.tx_tgl = ~q.tx_tgl;
                     next_q.state  = tws_pkg::TWS_TX;
                  end else begin
                     next_q.sda_oe = 1'b0;
                     next_q.state  = tws_pkg::TWS_RX;
                  end
               end
            end
            tws_pkg::TWS_TX: begin
               if (rise) begin
                  next_q.bitcnt = q.bitcnt + 4'h1;
               end else if (byte_done) begin
                  next_q.bitcnt = 4'h0;
                  next_q.sda_oe = 1'b0;
                  next_q.state  = tws_pkg::TWS_MACK;
               end else if (fall) begin
                  // Data moves only while SCL is low.
                  next_q.shreg  = {q.shreg[6:0], 1'b0};
                  next_q.sda_oe = ~q.shreg[6];
               end
            end
            tws_pkg::TWS_MACK: begin
               if (rise) begin
                  next_q.mack = ~q.sda_s2;
               end else if (fall) begin
                  if (q.mack) begin
                     next_q.shreg  = u.tx_data;
                     next_q.sda_oe = ~u.tx_data[7];
                     next_q.tx_tgl = ~q.tx_tgl;
                     next_q.state  = tws_pkg::TWS_TX;
                  end else begin
                     next_q.sda_oe = 1'b0;
                     next_q.state  = tws_pkg::TWS_IGNR;
                  end
               end
            end
            default: begin
               next_q.state = tws_pkg::TWS_IDLE;
            end
         endcase
      end
   end

   // Oversampling on the link clock serves all three bus speeds alike.
   always_ff @(posedge link_clock) begin
      if (!link_rst_sync[1]) begin
         q <= '0;
         q.scl_s1 <= 1'b1;
         q.scl_s2 <= 1'b1;
         q.scl_d  <= 1'b1;
         q.sda_s1 <= 1'b1;
         q.sda_s2 <= 1'b1;
         q.sda_d  <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   always_comb begin
      next_u          = u;
      next_u.rx_s1    = q.rx_tgl;
      next_u.rx_s2    = u.rx_s1;
      next_u.rx_d     = u.rx_s2;
      next_u.tx_s1    = q.tx_tgl;
      next_u.tx_s2    = u.tx_s1;
      next_u.tx_d     = u.tx_s2;
      next_u.hs_s1    = q.hs;
      next_u.hs_s2    = u.hs_s1;
      next_u.rx_valid = u.rx_s2 ^ u.rx_d;
      // The byte is stable here: the link side holds it for a whole byte time.
      if (u.rx_s2 ^ u.rx_d) begin
         next_u.rx_data = q.rx_byte;
      end
      // A new byte write wins over the request that it answers.
      if (tx_write) begin
         next_u.tx_data = tx_data;
         next_u.tx_req  = 1'b0;
      end else if (u.tx_s2 ^ u.tx_d) begin
         next_u.tx_req = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         u <= '0;
      end else begin
         u <= next_u;
      end
   end

   assign bus.sda_dev_oe = q.sda_oe;
   assign rx_valid       = u.rx_valid;
   assign rx_data        = u.rx_data;
   assign tx_req         = u.tx_req;
   assign hs_active      = u.hs_s2;

endmodule
`default_nettype wire

/* rtl/tws_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tws_host (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Bus lines
   tws_bus_if.host          bus,
   // Commands
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire tws_pkg::tws_cmd_e cmd,
   input  wire logic [7:0]  cmd_wdata,
   input  wire logic        cmd_ack,
   input  wire tws_pkg::tws_speed_e speed,
   // Answers
   output logic             resp_valid,
   output logic [7:0]       resp_rdata,
   output logic             resp_ack
);

   tws_pkg::tws_host_s q;
   tws_pkg::tws_host_s next_q;
   logic               tick;

   function automatic logic [15:0] quarter(input tws_pkg::tws_speed_e s);
      logic [15:0] c;
      c = 16'(tws_pkg::FAST_QTR - 1);
      if (s == tws_pkg::TWS_SPD_STD) begin
         c = 16'(tws_pkg::STD_QTR - 1);
      end else if (s == tws_pkg::TWS_SPD_HS) begin
         c = 16'(tws_pkg::HS_QTR - 1);
      end
      return c;
   endfunction

   always_comb begin
      next_q            = q;
      next_q.sda_s1     = bus.sda;
      next_q.sda_s2     = q.sda_s1;
      next_q.resp_valid = 1'b0;
      tick              = (q.qcnt == 16'h0000);
      if (q.state == tws_pkg::TWS_H_IDLE) begin
         if (cmd_valid) begin
            next_q.qload    = quarter(speed);
            next_q.qcnt     = quarter(speed);
            next_q.phase    = 2'h0;
            next_q.bitcnt   = 4'h0;
            next_q.shreg    = cmd_wdata;
            next_q.ack_send = cmd_ack;
            unique case (cmd)
               tws_pkg::TWS_CMD_START: next_q.state = tws_pkg::TWS_H_START;
               tws_pkg::TWS_CMD_WRITE: next_q.state = tws_pkg::TWS_H_BYTE;
               tws_pkg::TWS_CMD_READ: begin
                  next_q.state = tws_pkg::TWS_H_BYTE;
                  next_q.shreg = 8'hff;
               end
               tws_pkg::TWS_CMD_STOP: next_q.state = tws_pkg::TWS_H_STOP;
            endcase
         end
      end else if (!tick) begin
         next_q.qcnt = q.qcnt - 16'h0001;
      end else begin
         next_q.qcnt  = q.qload;
         next_q.phase = q.phase + 2'h1;
         unique case (q.state)
            tws_pkg::TWS_H_START: begin
               // Works from idle and, as a repeated start, from SCL low.
               unique case (q.phase)
                  2'h0: next_q.sda_lvl = 1'b1;
                  2'h1: next_q.scl_lvl = 1'b1;
                  2'h2: next_q.sda_lvl = 1'b0;
                  2'h3: begin
                     next_q.scl_lvl    = 1'b0;
                     next_q.state      = tws_pkg::TWS_H_IDLE;
                     next_q.resp_valid = 1'b1;
                  end
               endcase
            end
            tws_pkg::TWS_H_STOP: begin
               unique case (q.phase)
                  2'h0: next_q.sda_lvl = 1'b0;
                  2'h1: next_q.scl_lvl = 1'b1;
                  2'h2: next_q.sda_lvl = 1'b1;
                  2'h3: begin
                     next_q.state      = tws_pkg::TWS_H_IDLE;
                     next_q.resp_valid = 1'b1;
                  end
               endcase
            end
            tws_pkg::TWS_H_BYTE: begin
               unique case (q.phase)
                  2'h0: begin
                     // A read holds SDA released; the ninth bit is the acknowledge.
                     if (q.bitcnt != tws_pkg::BITS_PER_BYTE) begin
                        next_q.sda_lvl = q.shreg[7];
                     end else begin
                        next_q.sda_lvl = ~q.ack_send;
                     end
                  end
                  2'h1: next_q.scl_lvl = 1'b1;
                  2'h2: begin
                     if (q.bitcnt != tws_pkg::BITS_PER_BYTE) begin
                        next_q.shreg = {q.shreg[6:0], q.sda_s2};
                     end else begin
                        next_q.resp_ack = ~q.sda_s2;
                     end
                  end
                  2'h3: begin
                     next_q.scl_lvl = 1'b0;
                     if (q.bitcnt == tws_pkg::BITS_PER_BYTE) begin
                        next_q.sda_lvl    = 1'b1;
                        next_q.state      = tws_pkg::TWS_H_IDLE;
                        next_q.resp_valid = 1'b1;
                        next_q.resp_rdata = q.shreg;
                     end else begin
                        next_q.bitcnt = q.bitcnt + 4'h1;
                     end
                  end
               endcase
            end
            default: next_q.state = tws_pkg::TWS_H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         q         <= '0;
         q.sda_s1  <= 1'b1;
         q.sda_s2  <= 1'b1;
         q.scl_lvl <= 1'b1;
         q.sda_lvl <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // A master code is just a written byte sent at low speed before switching up.
   assign cmd_ready       = (q.state == tws_pkg::TWS_H_IDLE);
   assign bus.scl_host_oe = ~q.scl_lvl;
   assign bus.sda_host_oe = ~q.sda_lvl;
   assign resp_valid      = q.resp_valid;
   assign resp_rdata      = q.resp_rdata;
   assign resp_ack        = q.resp_ack;

endmodule
`default_nettype wire

/* rtl/tws_pkg.sv */
package tws_pkg;

   // Rates of the local clock and of the three bus speeds.
   localparam int CLOCK_HZ = 200_000_000;
   localparam int STD_HZ   = 100_000;
   localparam int FAST_HZ  = 400_000;
   localparam int HS_HZ    = 3_400_000;

   // Quarter periods of SCL in local clock cycles, rounded up so the bus never runs fast.
   localparam int STD_QTR  = (CLOCK_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ);
   localparam int FAST_QTR = (CLOCK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ);
   localparam int HS_QTR   = (CLOCK_HZ + 4 * HS_HZ - 1) / (4 * HS_HZ);

   // Address byte layout.
   localparam logic [4:0] ADDR_FIXED    = 5'h12;
   localparam logic [4:0] MCODE_TOP     = 5'h01;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] ADDR_SETTLE   = 2'h2;

   typedef enum logic [2:0] {
      TWS_IDLE = 3'h0,
      TWS_ADDR = 3'h1,
      TWS_ACK  = 3'h3,
      TWS_RX   = 3'h2,
      TWS_TX   = 3'h6,
      TWS_MACK = 3'h7,
      TWS_IGNR = 3'h5
   } tws_dev_state_e;

   typedef enum logic [1:0] {
      TWS_H_IDLE  = 2'h0,
      TWS_H_START = 2'h1,
      TWS_H_BYTE  = 2'h3,
      TWS_H_STOP  = 2'h2
   } tws_host_state_e;

   typedef enum logic [1:0] {
      TWS_CMD_START = 2'h0,
      TWS_CMD_WRITE = 2'h1,
      TWS_CMD_READ  = 2'h2,
      TWS_CMD_STOP  = 2'h3
   } tws_cmd_e;

   typedef enum logic [1:0] {
      TWS_SPD_STD  = 2'h0,
      TWS_SPD_FAST = 2'h1,
      TWS_SPD_HS   = 2'h2
   } tws_speed_e;

   // Link-side state of the device end.
   typedef struct packed {
      logic           scl_s1;
      logic           scl_s2;
      logic           scl_d;
      logic           sda_s1;
      logic           sda_s2;
      logic           sda_d;
      logic [1:0]     pin_s1;
      logic [1:0]     pin_s2;
      logic [1:0]     settle;
      logic [1:0]     addr_lo;
      tws_dev_state_e state;
      logic [3:0]     bitcnt;
      logic [7:0]     shreg;
      logic           dir_read;
      logic           mack;
      logic           sda_oe;
      logic           hs;
      logic [7:0]     rx_byte;
      logic           rx_tgl;
      logic           tx_tgl;
   } tws_link_s;

   // User-side state of the device end.
   typedef struct packed {
      logic       rx_s1;
      logic       rx_s2;
      logic       rx_d;
      logic       tx_s1;
      logic       tx_s2;
      logic       tx_d;
      logic       hs_s1;
      logic       hs_s2;
      logic       rx_valid;
      logic [7:0] rx_data;
      logic       tx_req;
      logic [7:0] tx_data;
   } tws_user_s;

   // State of the host end.
   typedef struct packed {
      logic            sda_s1;
      logic            sda_s2;
      tws_host_state_e state;
      logic [1:0]      phase;
      logic [3:0]      bitcnt;
      logic [15:0]     qcnt;
      logic [15:0]     qload;
      logic            scl_lvl;
      logic            sda_lvl;
      logic [7:0]      shreg;
      logic            ack_send;
      logic            resp_valid;
      logic [7:0]      resp_rdata;
      logic            resp_ack;
   } tws_host_s;

endpackage

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
   localparam logic [1:0] STRAP   = 2'h2;
   localparam logic [7:0] ADDR_WR = {tws_pkg::ADDR_FIXED, STRAP, 1'b0};
   localparam logic [7:0] ADDR_RD = {tws_pkg::ADDR_FIXED, STRAP, 1'b1};
   logic                clock;
   logic                link_clock;
   logic                rstn;
   logic                cmd_valid;
   logic                cmd_ready;
   tws_pkg::tws_cmd_e   cmd;
   logic [7:0]          cmd_wdata;
   logic                cmd_ack;
   tws_pkg::tws_speed_e speed;
   logic                resp_valid;
   logic [7:0]          resp_rdata;
   logic                resp_ack;
   logic                rx_valid;
   logic [7:0]          rx_data;
   logic                tx_write;
   logic [7:0]          tx_data;
   logic                tx_req;
   logic                hs_active;
   logic [7:0]          rx_q[$];
   int                  num_errors;
   int                  n_checks;
   logic [1:0]          link_rstn_sync = 2'h0;

   tws_bus_if bus ();

   tws_host i_tws_host (.clock(clock), .rstn(rstn), .bus(bus), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack),
      .speed(speed), .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_ack(resp_ack));

   tws_device i_tws_device (.clock(clock), .rstn(rstn), .link_clock(link_clock), .bus(bus),
      .addr_select_hi_pin(STRAP[1]), .addr_select_lo_pin(STRAP[0]), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_write(tx_write), .tx_data(tx_data), .tx_req(tx_req),
      .hs_active(hs_active));

   // The checker watches link-side drivers, so its reset follows the link domain's.
   always @(posedge link_clock) begin
      link_rstn_sync <= {link_rstn_sync[0], rstn};
   end

   tws_checker i_tws_checker (.link_clock(link_clock), .rstn(link_rstn_sync[1]), .scl(bus.scl),
      .sda(bus.sda), .scl_host_oe(bus.scl_host_oe), .sda_host_oe(bus.sda_host_oe),
      .sda_dev_oe(bus.sda_dev_oe));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Odd offset keeps the link clock out of step with the user clock.
   initial begin
      link_clock = 1'b0;
      #1.3;
      forever #3 link_clock = ~link_clock;
   end

   always @(negedge clock) begin
      if (rx_valid === 1'b1) begin
         rx_q.push_back(rx_data);
      end
   end

   task automatic end_sim();
      $display("Checks %0d, errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wait_on(inout int n);
      n++;
      if (n > 30000) begin
         num_errors++;
         $display("Error at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
         end_sim();
      end else begin
         @(negedge clock);
      end
   endtask

   // A standard-rate byte takes some 18000 cycles, hence the wide bound.
   task automatic send(input tws_pkg::tws_cmd_e c, input logic [7:0] d, input logic a);
      int n;
      n = 0;
      @(negedge clock);
      cmd = c;
      cmd_wdata = d;
      cmd_ack = a;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) wait_on(n);
      @(negedge clock);
      cmd_valid = 1'b0;
      n = 0;
      while (resp_valid !== 1'b1) wait_on(n);
   endtask

   task automatic st();
      send(tws_pkg::TWS_CMD_START, 8'h00, 1'b0);
   endtask

   task automatic sp();
      send(tws_pkg::TWS_CMD_STOP, 8'h00, 1'b0);
   endtask

   task automatic wr(input logic [7:0] d, input logic exp_ack);
      send(tws_pkg::TWS_CMD_WRITE, d, 1'b0);
      `CHK(resp_ack, exp_ack)
   endtask

   task automatic rd(input logic a, input logic [7:0] exp);
      send(tws_pkg::TWS_CMD_READ, 8'h00, a);
      `CHK(resp_rdata, exp)
   endtask

   task automatic load(input logic [7:0] d);
      @(negedge clock);
      tx_data = d;
      tx_write = 1'b1;
      @(negedge clock);
      tx_write = 1'b0;
   endtask

   task automatic wait_req();
      int n;
      n = 0;
      while (tx_req !== 1'b1) wait_on(n);
   endtask

   task automatic t_write();
      logic [7:0] d[3] = '{8'h00, 8'hff, 8'ha5};
      speed = tws_pkg::TWS_SPD_FAST;
      rx_q.delete();
      st();
      wr(ADDR_WR, 1'b1);
      foreach (d[i]) wr(d[i], 1'b1);
      sp();
      `CHK(rx_q.size(), 3)
      foreach (d[i]) `CHK(rx_q[i], d[i])
      `CHK(hs_active, 1'b0)
   endtask

   task automatic t_hs();
      speed = tws_pkg::TWS_SPD_FAST;
      rx_q.delete();
      st();
      wr(8'h08, 1'b0);
      repeat (20) @(negedge clock);
      `CHK(hs_active, 1'b1)
      speed = tws_pkg::TWS_SPD_HS;
      st();
      wr(ADDR_WR, 1'b1);
      wr(8'h3c, 1'b1);
      st();
      wr(8'h0f, 1'b0);
      `CHK(hs_active, 1'b1)
      st();
      wr(ADDR_WR, 1'b1);
      sp();
      repeat (20) @(negedge clock);
      `CHK(hs_active, 1'b0)
      `CHK(rx_q.size(), 1)
      `CHK(rx_q[0], 8'h3c)
   endtask

   // The holding byte must be in place before the address ack ends.
   task automatic t_read();
      speed = tws_pkg::TWS_SPD_FAST;
      rx_q.delete();
      load(8'h3c);
      st();
      wr(ADDR_RD, 1'b1);
      wait_req();
      load(8'hc3);
      rd(1'b1, 8'h3c);
      wait_req();
      rd(1'b0, 8'hc3);
      sp();
      `CHK(rx_q.size(), 0)
   endtask

   // Own address sent as data after a mismatch must still be ignored.
   task automatic t_other_addr();
      logic [7:0] a[4] = '{8'h90, 8'h92, 8'h96, 8'hd4};
      speed = tws_pkg::TWS_SPD_FAST;
      rx_q.delete();
      foreach (a[i]) begin
         st();
         wr(a[i], 1'b0);
      end
      speed = tws_pkg::TWS_SPD_STD;
      wr(ADDR_WR, 1'b0);
      sp();
      `CHK(rx_q.size(), 0)
   endtask

   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd = tws_pkg::TWS_CMD_START;
      cmd_wdata = 8'h00;
      cmd_ack = 1'b0;
      speed = tws_pkg::TWS_SPD_FAST;
      tx_write = 1'b0;
      tx_data = 8'h00;
      num_errors = 0;
      n_checks = 0;
      repeat (3) @(negedge clock);
      rstn = 1'b1;
      repeat (20) @(negedge clock);
      `CHK(bus.sda, 1'b1)
      t_write();
      t_hs();
      t_read();
      t_other_addr();
      end_sim();
   end
endmodule
`default_nettype wire

/* tb/tws_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tws_checker (
   // Link clock and reset
   input wire logic link_clock,
   input wire logic rstn,
   // Bus lines and their drivers
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_host_oe,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe
);
   logic       scl_q;
   logic       sda_q;
   logic       busy;
   logic [3:0] rises;

   default clocking cb @(posedge link_clock);
   endclocking
   default disable iff (!rstn);

   // SCL rises are counted modulo nine inside a frame, so a start or stop that lands
   // anywhere but just after a whole number of bytes shows up at once.
   always_ff @(posedge link_clock) begin
      if (!rstn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         busy  <= 1'b0;
         rises <= 4'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (scl && scl_q && (sda != sda_q)) begin
            busy  <= !sda;
            rises <= 4'h0;
         end else if (scl && !scl_q) begin
            rises <= (rises == 4'h8) ? 4'h0 : rises + 4'h1;
         end
      end
   end

   sequence s_start;
      scl && $past(scl) && $fell(sda);
   endsequence

   sequence s_stop;
      scl && $past(scl) && $rose(sda);
   endsequence

   a_start_by_host: assert property (s_start |-> sda_host_oe)
      else $error("start condition not made by the host");
   a_stop_released: assert property (s_stop |-> !sda_dev_oe && !$past(sda_dev_oe))
      else $error("device held SDA at a stop");
   a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
      else $error("device moved SDA while SCL high");
   a_frame_whole_bytes: assert property ((s_start or s_stop) |-> rises == 4'h1 || !busy)
      else $error("start or stop not after whole nine-bit units");
   a_idle_released: assert property (!busy |-> !sda_dev_oe)
      else $error("device drives SDA on an idle bus");
   a_ack_held: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
      else $error("device low pulse too short");
   a_ack_spans_pulse: assert property
      ($rose(sda_dev_oe) |-> sda_dev_oe throughout (##[1:1000] $rose(scl)))
      else $error("device released SDA before the clock pulse");
   a_dev_pull_low: assert property (sda_dev_oe |-> !sda)
      else $error("device drive did not pull SDA low");
   a_scl_by_host: assert property (!scl |-> scl_host_oe)
      else $error("SCL low without the host driving it");
endmodule
`default_nettype wire
